// ===== register_map_access_policy.sv
`timescale 1ns/10ps
module register_map_access_policy (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Request from the deframer
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic [7:0] req_pec,
  input wire logic [7:0] req_count,
  input wire logic req_proto_ok,
  // Internal operation in progress
  input wire logic busy_valid,
  input wire logic [7:0] busy_addr,
  // Answer
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [7:0] rsp_pec,
  output logic rsp_last,
  output logic wr_done,
  output logic wr_rejected,
  // Status
  output logic [15:0] first_alert_summary_word,
  output logic [15:0] second_alert_summary_word,
  output logic write_rejected_alert
);
  typedef struct packed {
    regmap_pkg::phase_e phase;
    logic [7:0] blk_addr;
    logic [7:0] blk_left;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic [7:0] rsp_pec;
    logic rsp_last;
    logic wr_done;
    logic wr_rejected;
    logic [regmap_pkg::USER_DEPTH-1:0][15:0] regs;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  regmap_if lnk();

  logic [7:0] cur_addr;
  logic [15:0] rd_word;
  logic take;
  logic pec_ok;
  logic busy_hit;
  logic [15:0] set1;
  logic [15:0] set2;

  addr_decode u_dec (
    .dif(lnk.decoder)
  );

  word_pec u_pec (
    .cif(lnk.crc_side)
  );

  // Address under decode follows the block walk
  always_comb begin
    if (st_r.phase == regmap_pkg::PH_BLOCK) begin
      cur_addr = st_r.blk_addr;
    end else begin
      cur_addr = req_addr;
    end
  end

  // Read value of the address under decode
  always_comb begin
    if (lnk.reserved) begin
      rd_word = 16'h0000; // [R6] [R7]
    end else begin
      rd_word = st_r.regs[cur_addr] & lnk.mask; // [R9] [R10]
    end
  end

  assign lnk.addr = cur_addr;
  assign lnk.wdata = req_wdata;
  assign lnk.rdata = rd_word;

  assign req_ready = (st_r.phase == regmap_pkg::PH_IDLE);
  assign take = req_valid && req_ready;
  assign pec_ok = (lnk.wr_pec == req_pec); // [R8]
  assign busy_hit = busy_valid && (busy_addr == req_addr);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.rsp_last = 1'b0;
    st_nxt.wr_done = 1'b0;
    st_nxt.wr_rejected = 1'b0;
    set1 = 16'h0000;
    set2 = 16'h0000;
    case (st_r.phase)
      regmap_pkg::PH_IDLE: begin
        if (take) begin
          if (!req_proto_ok) begin
            set1[regmap_pkg::S1_PROTO_BIT] = 1'b1; // [R1]
          end else if (req_write && !pec_ok) begin
            set1[regmap_pkg::S1_PEC_BIT] = 1'b1; // [R1]
          end else if (req_write) begin
            st_nxt.wr_done = 1'b1;
            if (busy_hit) begin
              st_nxt.wr_rejected = 1'b1; // [R12]
              set2[regmap_pkg::S2_RJCT_BIT] = 1'b1; // [R12]
            end else if (!lnk.reserved) begin
              st_nxt.regs[req_addr] = req_wdata & lnk.mask; // [R9] [R10]
            end
            // Reserved write falls through silently [R5] [R6]
          end else begin
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp_data = rd_word; // [R5] [R6]
            st_nxt.rsp_pec = lnk.rd_pec; // [R8]
            st_nxt.blk_addr = req_addr + 8'h01;
            if (req_count > 8'h01) begin
              st_nxt.blk_left = req_count - 8'h01;
              st_nxt.phase = regmap_pkg::PH_BLOCK;
            end else begin
              st_nxt.rsp_last = 1'b1;
            end
          end
        end
      end
      regmap_pkg::PH_BLOCK: begin
        st_nxt.rsp_valid = 1'b1;
        st_nxt.rsp_data = rd_word; // [R7]
        st_nxt.rsp_pec = lnk.rd_pec; // [R8]
        st_nxt.blk_addr = st_r.blk_addr + 8'h01; // [R7]
        st_nxt.blk_left = st_r.blk_left - 8'h01;
        if (st_r.blk_left == 8'h01) begin
          st_nxt.rsp_last = 1'b1;
          st_nxt.phase = regmap_pkg::PH_IDLE;
        end
      end
      default: begin
        st_nxt.phase = regmap_pkg::PH_IDLE;
      end
    endcase
    // Alert set wins over a same-cycle software write
    st_nxt.regs[regmap_pkg::ALERT1_ADDR] =
      st_nxt.regs[regmap_pkg::ALERT1_ADDR] | (set1 & regmap_pkg::S1_MASK);
    st_nxt.regs[regmap_pkg::ALERT2_ADDR] =
      st_nxt.regs[regmap_pkg::ALERT2_ADDR] | (set2 & regmap_pkg::S2_MASK);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_valid = st_r.rsp_valid;
  assign rsp_data = st_r.rsp_data;
  assign rsp_pec = st_r.rsp_pec;
  assign rsp_last = st_r.rsp_last;
  assign wr_done = st_r.wr_done;
  assign wr_rejected = st_r.wr_rejected;
  assign first_alert_summary_word = st_r.regs[regmap_pkg::ALERT1_ADDR];
  assign second_alert_summary_word = st_r.regs[regmap_pkg::ALERT2_ADDR];
  assign write_rejected_alert =
    st_r.regs[regmap_pkg::ALERT2_ADDR][regmap_pkg::S2_RJCT_BIT];
endmodule

// ===== regmap_pkg.sv
// Notes on behaviour
// [R1] A request with a protocol or check error is dropped and sets an alert.
// [R2] User registers lie in 0x00 to 0x98, unlisted ones there are reserved.
// [R3] Addresses 0x2C to 0x2F and 0x46 are reserved and hold no register.
// [R4] Addresses 0x99 to 0xFF are reserved maker space outside the user map.
// [R5] A valid access to a reserved address raises no error.
// [R6] Writes to a reserved address are dropped, and reads of one return zero.
// [R7] A block readback gives zero for each reserved address and skips none.
// [R8] The check code covers all 16 data bits of a word, unused bits included.
// [R9] Unused bits of a defined register are not stored and read as zero.
// [R10] Both config spare fields store and read back data and steer nothing.
// [R11] Host software should avoid writing reserved addresses.
// [R12] A valid write to a busy register is ignored and sets the reject alert.
// [R13] Addresses decode as 8 bits, each one a register or reserved.
package regmap_pkg;
  localparam logic [7:0] USER_LAST = 8'h98;
  localparam logic [7:0] RSV_LO_FIRST = 8'h2C;
  localparam logic [7:0] RSV_LO_LAST = 8'h2F;
  localparam logic [7:0] RSV_SINGLE = 8'h46;
  localparam logic [7:0] MFR_FIRST = 8'h99;
  localparam int USER_DEPTH = 153;
  localparam logic [7:0] ALERT1_ADDR = 8'h02;
  localparam logic [7:0] ALERT2_ADDR = 8'h03;
  localparam logic [7:0] CFG1_ADDR = 8'h10;
  localparam logic [7:0] CFG2_ADDR = 8'h11;
  localparam int S1_PEC_BIT = 5;
  localparam int S1_PROTO_BIT = 4;
  localparam int S2_RJCT_BIT = 0;
  localparam logic [15:0] S1_MASK = 16'hFFBF;
  localparam logic [15:0] S2_MASK = 16'hFE05;
  localparam logic [15:0] CFG1_SPARE_MASK = 16'hF000;
  localparam logic [15:0] CFG2_SPARE_MASK = 16'hF800;
  localparam logic [15:0] CFG_MASK = 16'hFFFF;
  localparam logic [15:0] DEF_MASK = 16'hFFFF;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] PEC_POLY = 8'hA6;
  localparam logic [7:0] PEC_INIT = 8'h00;

  typedef enum logic {PH_IDLE, PH_BLOCK} phase_e;

  function automatic logic is_reserved(input logic [7:0] a);
    is_reserved = (a >= MFR_FIRST) || (a > USER_LAST) ||
                   ((a >= RSV_LO_FIRST) && (a <= RSV_LO_LAST)) ||
                   (a == RSV_SINGLE);
  endfunction
endpackage

// ===== regmap_if.sv
`timescale 1ns/10ps
interface regmap_if;
  logic [7:0] addr;
  logic reserved;
  logic [15:0] mask;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [7:0] wr_pec;
  logic [7:0] rd_pec;
  modport policy(output addr, wdata, rdata,
                 input reserved, mask, wr_pec, rd_pec);
  modport decoder(input addr, output reserved, mask);
  modport crc_side(input wdata, rdata, output wr_pec, rd_pec);
endinterface

// ===== addr_decode.sv
`timescale 1ns/10ps
module addr_decode (
  // Decode link
  regmap_if.decoder dif
);
  always_comb begin
    dif.reserved = regmap_pkg::is_reserved(dif.addr); // [R2] [R3] [R4] [R13]
    case (dif.addr)
      regmap_pkg::ALERT1_ADDR: dif.mask = regmap_pkg::S1_MASK; // [R9]
      regmap_pkg::ALERT2_ADDR: dif.mask = regmap_pkg::S2_MASK; // [R9]
      regmap_pkg::CFG1_ADDR: dif.mask = regmap_pkg::CFG_MASK; // [R10]
      regmap_pkg::CFG2_ADDR: dif.mask = regmap_pkg::CFG_MASK; // [R10]
      default: dif.mask = regmap_pkg::DEF_MASK;
    endcase
  end
endmodule

// ===== word_pec.sv
`timescale 1ns/10ps
module word_pec (
  // Check link
  regmap_if.crc_side cif
);
  // Bitwise code over all 16 bits, MSB first
  function automatic logic [7:0] crc16b(input logic [15:0] d);
    logic [7:0] c;
    c = regmap_pkg::PEC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ regmap_pkg::PEC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc16b = c;
  endfunction

  always_comb begin
    cif.wr_pec = crc16b(cif.wdata); // [R8]
    cif.rd_pec = crc16b(cif.rdata); // [R8]
  end
endmodule

// ===== register_map_access_policy_properties.sv
`timescale 1ns/10ps
module policy_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Request
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic [7:0] req_pec,
  input wire logic [7:0] req_count,
  input wire logic req_proto_ok,
  // Internal operation
  input wire logic busy_valid,
  input wire logic [7:0] busy_addr,
  // Answer
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [7:0] rsp_pec,
  input wire logic rsp_last,
  input wire logic wr_done,
  input wire logic wr_rejected,
  // Status
  input wire logic [15:0] first_alert_summary_word,
  input wire logic [15:0] second_alert_summary_word,
  input wire logic write_rejected_alert
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic tk, rdok;
  assign tk = req_valid && req_ready;
  assign rdok = tk && !req_write && req_proto_ok;
  property p_proto;
    tk && !req_proto_ok |=> !rsp_valid && !wr_done &&
      first_alert_summary_word[4];
  endproperty
  a_proto: assert property (p_proto) else $error("bad frame answered");
  property p_resv;
    rdok && (req_addr inside {[8'h2C:8'h2F], 8'h46, [8'h99:8'hFF]})
      |=> rsp_valid && rsp_data == 16'h0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved not zero");
  property p_noerr;
    rdok |=> $stable(first_alert_summary_word);
  endproperty
  a_noerr: assert property (p_noerr) else $error("read raised alert");
  property p_blk;
    rdok && req_count == 8'h03 |=> (rsp_valid && !req_ready && !rsp_last)[*2]
      ##1 (rsp_valid && rsp_last && req_ready);
  endproperty
  a_blk: assert property (p_blk) else $error("block walk wrong");
  property p_single;
    rdok && req_count <= 8'h01 |=> rsp_valid && rsp_last && req_ready;
  endproperty
  a_single: assert property (p_single) else $error("single read");
  property p_rej;
    tk && req_write && req_proto_ok && busy_valid && busy_addr == req_addr
      |=> !wr_done || (wr_rejected && write_rejected_alert);
  endproperty
  a_rej: assert property (p_rej) else $error("busy write kept");
  property p_unused;
    !first_alert_summary_word[6] &&
      (second_alert_summary_word & ~regmap_pkg::S2_MASK) == 16'h0000;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_flag;
    $rose(write_rejected_alert) |-> (wr_rejected && wr_done) ||
      $past(tk && req_write && req_addr == 8'h03);
  endproperty
  a_flag: assert property (p_flag) else $error("alert without cause");
endmodule
bind register_map_access_policy policy_checker u_chk (.*);

// ===== host_model.sv
`timescale 1ns/10ps
module host_model (
  // Clock and handshake
  input wire logic clk,
  input wire logic req_ready,
  // Request
  output logic req_valid,
  output logic req_write,
  output logic req_proto_ok,
  output logic [7:0] req_addr,
  output logic [7:0] req_pec,
  output logic [7:0] req_count,
  output logic [15:0] req_wdata
);
  function automatic logic [7:0] pec(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'hA6 : 8'h00);
    return c;
  endfunction
  initial {req_valid, req_write, req_proto_ok, req_addr, req_pec} = '0;
  initial {req_count, req_wdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, n,
                      input logic [15:0] d, input logic ok, bad);
    @(posedge clk);
    #1;
    {req_valid, req_write, req_addr, req_count} = {1'b1, w, a, n};
    {req_wdata, req_proto_ok} = {d, ok};
    req_pec = pec(d) ^ {7'h00, bad};
    while (!req_ready) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_wdata = ~d;
    req_addr = ~a;
  endtask
endmodule

// ===== tb_register_map_access_policy.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_register_map_access_policy;
  logic clk = 0, resetn = 0, busy_valid = 0;
  logic [7:0] busy_addr = 8'h00, a;
  logic req_valid, req_ready, req_write, req_proto_ok, rsp_valid, rsp_last;
  logic wr_done, wr_rejected, write_rejected_alert;
  logic [7:0] req_addr, req_pec, req_count, rsp_pec;
  logic [15:0] req_wdata, rsp_data;
  logic [15:0] first_alert_summary_word, second_alert_summary_word;
  logic [15:0] mem [256] = '{default: 16'h0000};
  logic [7:0] ra [7] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h46, 8'h99, 8'hFF};
  int bad_count = 0, checks_done = 0;
  integer seed = 32'h0de5edcc;
  always #12.5 clk = ~clk;
  host_model u_host (.*);
  register_map_access_policy u_dut (.*);
  function automatic logic rsv(input logic [7:0] x);
    return x > 8'h98 || (x >= 8'h2C && x <= 8'h2F) || x == 8'h46;
  endfunction
  task automatic rd(input logic [7:0] x, n);
    int c;
    c = (n > 8'h01) ? int'(n) : 1;
    u_host.xfer(0, x, n, 16'h0000, 1, 0);
    for (int i = 0; i < c; i++) begin
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_data, mem[x])
      `CHK(rsp_pec, u_host.pec(mem[x]))
      `CHK(rsp_last, 1'(i == c - 1))
      x = x + 8'h01;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wr(input logic [7:0] x, input logic [15:0] d,
                    input logic ok, bad, bsy);
    busy_valid = bsy;
    busy_addr = bsy ? x : ~x;
    u_host.xfer(1, x, 8'h00, d, ok, bad);
    if (!ok) mem[2] = mem[2] | 16'h0010;
    else if (bad) mem[2] = mem[2] | 16'h0020;
    else if (bsy) mem[3] = mem[3] | 16'h0001;
    else if (!rsv(x)) mem[x] = d & (x == 8'h02 ? regmap_pkg::S1_MASK :
      x == 8'h03 ? regmap_pkg::S2_MASK : 16'hFFFF);
    `CHK(wr_done, ok && !bad)
    `CHK(wr_rejected, ok && !bad && bsy)
    `CHK(first_alert_summary_word, mem[2])
    `CHK(second_alert_summary_word, mem[3])
    busy_valid = 0;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 resetn = 1;
    `CHK(req_ready, 1'b1)
    repeat (20) begin
      a = 8'({$random(seed)} % 153);
      if (rsv(a) || a inside {8'h02, 8'h03}) a = 8'h10;
      wr(a, 16'($random(seed)), 1, 0, 0);
      rd(a, 8'h01);
    end
    $display("test storage done");
    foreach (ra[i]) begin
      wr(ra[i], 16'hFFFF, 1, 0, 0);
      rd(ra[i], 8'h00);
    end
    $display("test reserved done");
    wr(8'h10, 16'hF000, 1, 0, 0);
    wr(8'h11, 16'hF800, 1, 0, 0);
    wr(8'h02, 16'hFFFF, 1, 0, 0);
    rd(8'h02, 8'h01);
    wr(8'h02, 16'h0000, 1, 0, 0);
    wr(8'h03, 16'hFFFF, 1, 0, 0);
    rd(8'h03, 8'h01);
    wr(8'h03, 16'h0000, 1, 0, 0);
    rd(8'h10, 8'h02);
    $display("test fields done");
    rd(8'h2B, 8'h03);
    rd(8'hFE, 8'h03);
    rd(8'h2A, 8'h06);
    $display("test block done");
    wr(8'h20, 16'h1234, 1, 1, 0);
    wr(8'h2C, 16'h1234, 0, 0, 0);
    wr(8'h20, 16'h5555, 1, 0, 1);
    `CHK(write_rejected_alert, 1'b1)
    rd(8'h20, 8'h01);
    $display("test errors done");
    finish_test;
  end
endmodule
